// ### pkg/lcm_params.svh
// Offsets, reset values and field positions of the LAN register bank
`ifndef LCM_PARAMS_SVH
`define LCM_PARAMS_SVH

// Register window
`define LCM_WIN_BASE 8'h00
`define LCM_WIN_TOP 8'hFC

// Register byte offsets
`define LCM_OFF_BUS_ACCESS 8'h00
`define LCM_OFF_TX_POLL 8'h08
`define LCM_OFF_RX_POLL 8'h10
`define LCM_OFF_RX_RING 8'h18
`define LCM_OFF_TX_RING 8'h20
`define LCM_OFF_MAIN_STAT 8'h28
`define LCM_OFF_NET_ACCESS 8'h30
`define LCM_OFF_IEN_MAIN 8'h38
`define LCM_OFF_DROP_CNT 8'h40
`define LCM_OFF_SERIAL 8'h48
`define LCM_OFF_GEN_TIMER 8'h58
`define LCM_OFF_WAKEUP 8'h68
`define LCM_OFF_WATCHDOG 8'h78
`define LCM_OFF_SEC_STAT 8'h80
`define LCM_OFF_IEN_SEC 8'h84
`define LCM_OFF_COMMAND 8'h88
`define LCM_OFF_PERF_CNT 8'h8C
`define LCM_OFF_POWER 8'h90
`define LCM_OFF_TX_DPTR 8'h94
`define LCM_OFF_RX_DPTR 8'h98
`define LCM_OFF_TX_BURST 8'h9C
`define LCM_OFF_FLASH 8'hA0
`define LCM_OFF_STA_LO 8'hA4
`define LCM_OFF_STA_HI 8'hA8
`define LCM_OFF_GRP_LO 8'hAC
`define LCM_OFF_GRP_HI 8'hB0
`define LCM_OFF_SGL_LO 8'hB4
`define LCM_OFF_SGL_HI 8'hB8
`define LCM_OFF_OP_MODE 8'hFC

// Reset values
`define LCM_RST_BUS_ACCESS 32'h0000_1000
`define LCM_RST_ZERO 32'h0000_0000

// Serial port: low half is read live from the pins
`define LCM_SER_LIVE_W 16
`define LCM_SER_CTRL_LSB 16

// Word index field of the byte address
`define LCM_IDX_MSB 7
`define LCM_IDX_LSB 2

`endif

// ### pkg/lcm_pkg.sv
// Types shared by the LAN register bank
package lcm_pkg;

  typedef enum logic [2:0] {
    LCM_ACC_LHSC = 3'h0,
    LCM_ACC_LLSC = 3'h1,
    LCM_ACC_IHSC = 3'h2,
    LCM_ACC_ILSC = 3'h3,
    LCM_ACC_LHMK = 3'h4,
    LCM_ACC_LLMK = 3'h5,
    LCM_ACC_IHMK = 3'h6,
    LCM_ACC_ILMK = 3'h7
  } lcm_acc_e;

  typedef struct packed {
    logic sel;
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
  } lcm_req_s;

  typedef struct packed {
    logic [31:0] main_src;
    logic [31:0] sec_src;
    logic [31:0] drop_cnt;
    logic [31:0] perf_cnt;
    logic [31:0] tx_dptr;
    logic [31:0] rx_dptr;
    logic [15:0] serial_pins;
    logic tmr_upd;
    logic [31:0] tmr_val;
    logic tx_poll_done;
    logic rx_poll_done;
    logic [31:0] strap;
  } lcm_hw_s;

  typedef struct packed {
    logic [31:0] bus_access;
    logic [31:0] rx_ring_base;
    logic [31:0] tx_ring_base;
    logic [31:0] net_access;
    logic [15:0] serial_ctrl;
    logic [31:0] gen_timer;
    logic [31:0] wakeup;
    logic [31:0] watchdog;
    logic [31:0] command;
    logic [31:0] power;
    logic [31:0] tx_burst;
    logic [31:0] flash_port;
    logic [31:0] sta_lo;
    logic [31:0] sta_hi;
    logic [31:0] grp_lo;
    logic [31:0] grp_hi;
    logic [31:0] sgl_lo;
    logic [31:0] sgl_hi;
    logic [31:0] op_mode;
  } lcm_ctrl_s;

endpackage

// ### verif/lcm_csr_bank_monitor.sv
// Port checker for the LAN register bank
module lcm_csr_bank_monitor (
  input wire logic ref_clk,
  input wire logic rst,
  input wire lcm_pkg::lcm_req_s csr_req,
  input wire logic [31:0] csr_rdata,
  input wire logic csr_rvalid,
  input wire lcm_pkg::lcm_hw_s hw,
  input wire lcm_pkg::lcm_ctrl_s ctrl,
  input wire logic tx_poll_stb,
  input wire logic rx_poll_stb,
  input wire logic irq_main,
  input wire logic irq_sec
);
  timeunit 1ns;
  timeprecision 1ps;
  import lcm_pkg::*;
  logic rd;
  logic wr;
  logic [7:0] ad;
  assign rd = csr_req.sel & ~csr_req.wr;
  assign wr = csr_req.sel & csr_req.wr;
  assign ad = csr_req.addr;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  property p_rvalid;
    1'b1 |=> csr_rvalid == $past(rd);
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("read valid pulse wrong");
  property p_unmapped;
    rd && ad[7:6] == 2'b11 && ad[5:2] != 4'hF |=> csr_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unassigned word not zero");
  property p_ro_reg;
    rd && ad == 8'h40 && !$past(rst) |=> csr_rdata == $past(hw.drop_cnt, 2);
  endproperty
  a_ro_reg: assert property (p_ro_reg) else $error("dropped count not one stage behind");
  property p_live;
    rd && ad == 8'h48 |=> csr_rdata[15:0] == $past(hw.serial_pins);
  endproperty
  a_live: assert property (p_live) else $error("live pins not passed through");
  property p_tx_stb;
    1'b1 |=> tx_poll_stb == $past(wr && ad == 8'h08);
  endproperty
  a_tx_stb: assert property (p_tx_stb) else $error("transmit strobe wrong");
  property p_rx_stb;
    wr && ad == 8'h10 |=> rx_poll_stb ##1 (!rx_poll_stb || $past(wr && ad == 8'h10));
  endproperty
  a_rx_stb: assert property (p_rx_stb) else $error("receive strobe not one cycle");
  property p_ring;
    wr && ad == 8'h18 |=> ctrl.rx_ring_base == $past(csr_req.wdata);
  endproperty
  a_ring: assert property (p_ring) else $error("receive ring base not written");
  property p_timer;
    wr && ad == 8'h58 |=> ctrl.gen_timer == $past(csr_req.wdata);
  endproperty
  a_timer: assert property (p_timer) else $error("timer write lost to hardware");
  property p_strap;
    $past(rst) && !(wr && ad == 8'h88) |=> ctrl.command == $past(hw.strap);
  endproperty
  a_strap: assert property (p_strap) else $error("command not loaded from strap");
  property p_irq_main_off;
    wr && ad == 8'h38 && csr_req.wdata == 32'h0 |=> ##1 !irq_main;
  endproperty
  a_irq_main_off: assert property (p_irq_main_off) else $error("main irq not gated");
  property p_irq_sec_off;
    wr && ad == 8'h84 && csr_req.wdata == 32'h0 |=> ##1 !irq_sec;
  endproperty
  a_irq_sec_off: assert property (p_irq_sec_off) else $error("secondary irq not gated");
  c_stat_rd: cover property (rd && ad == 8'h28);
  c_irq: cover property ($rose(irq_main));
  c_poll: cover property (tx_poll_stb);
endmodule

bind lcm_csr_bank lcm_csr_bank_monitor i_mon (.ref_clk(ref_clk), .rst(rst), .csr_req(csr_req),
  .csr_rdata(csr_rdata), .csr_rvalid(csr_rvalid), .hw(hw), .ctrl(ctrl), .tx_poll_stb(tx_poll_stb),
  .rx_poll_stb(rx_poll_stb), .irq_main(irq_main), .irq_sec(irq_sec));

// ### verif/lcm_csr_bank_tb.sv
// Self-checking testbench of the LAN register bank
module lcm_csr_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lcm_pkg::*;
  localparam logic [31:0] IDLE_SRC = 32'hFF00_FF00;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  lcm_req_s csr_req;
  logic [31:0] csr_rdata;
  logic csr_rvalid;
  lcm_hw_s hw;
  lcm_ctrl_s ctrl;
  logic tx_poll_stb;
  logic rx_poll_stb;
  logic irq_main;
  logic irq_sec;
  int mismatches = 0;
  int comparisons = 0;
  int seed = 30290;
  int cycles = 0;
  logic [7:0] rw_offs [20] = '{8'h00, 8'h18, 8'h20, 8'h30, 8'h38, 8'h58, 8'h68, 8'h78, 8'h84, 8'h88,
    8'h90, 8'h9C, 8'hA0, 8'hA4, 8'hA8, 8'hAC, 8'hB0, 8'hB4, 8'hB8, 8'hFC};
  logic [7:0] misc_offs [12] = '{8'h08, 8'h10, 8'h28, 8'h40, 8'h48, 8'h80, 8'h8C, 8'h94, 8'h98,
    8'h04, 8'hC0, 8'hF8};
  logic [7:0] ro_offs [4] = '{8'h40, 8'h8C, 8'h94, 8'h98};
  logic [31:0] v;
  logic [31:0] en;
  logic [7:0] a;

  always #5 ref_clk = ~ref_clk;

  lcm_csr_bank i_dut (.ref_clk(ref_clk), .rst(rst), .csr_req(csr_req), .csr_rdata(csr_rdata),
    .csr_rvalid(csr_rvalid), .hw(hw), .ctrl(ctrl), .tx_poll_stb(tx_poll_stb), .rx_poll_stb(rx_poll_stb),
    .irq_main(irq_main), .irq_sec(irq_sec));
  lcm_host_model i_host (.ref_clk(ref_clk), .csr_rdata(csr_rdata), .csr_rvalid(csr_rvalid),
    .csr_req(csr_req));

  function automatic logic [31:0] rst_val(input logic [7:0] off);
    if (off == 8'h00) return 32'h0000_1000;
    if (off == 8'h88) return hw.strap;
    return 32'h0;
  endfunction

  function automatic logic [31:0] ro_val(input logic [7:0] off);
    case (off)
      8'h40: return hw.drop_cnt;
      8'h8C: return hw.perf_cnt;
      8'h94: return hw.tx_dptr;
      default: return hw.rx_dptr;
    endcase
  endfunction

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input logic [7:0] off);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t word %h got %h expected %h", $time, off, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] off, input logic [31:0] exp);
    i_host.op(1'b0, off, 32'h0);
    check({31'h0, i_host.last_ok}, 32'h1, off);
    check(i_host.last_rd, exp, off);
  endtask

  task automatic wr(input logic [7:0] off, input logic [31:0] d);
    i_host.op(1'b1, off, d);
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles > 8000) begin
      mismatches++;
      conclude();
    end
  end

  initial begin
    hw = '0;
    hw.main_src = IDLE_SRC;
    hw.sec_src = IDLE_SRC;
    hw.strap = $random(seed);
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (rw_offs[i]) rd(rw_offs[i], rst_val(rw_offs[i]));
    foreach (misc_offs[i]) rd(misc_offs[i], 32'h0);
    $display("test reset values done");
    foreach (rw_offs[i]) begin
      v = $random(seed);
      wr(rw_offs[i], v);
      rd(rw_offs[i], v);
    end
    wr(8'hC4, 32'hFFFF_FFFF);
    rd(8'hC4, 32'h0);
    $display("test read write map done");
    for (int k = 0; k < 2; k++) begin
      a = k ? 8'h10 : 8'h08;
      v = $random(seed);
      wr(a, v);
      check({31'h0, k ? rx_poll_stb : tx_poll_stb}, 32'h1, a);
      rd(a, v);
      check({31'h0, k ? rx_poll_stb : tx_poll_stb}, 32'h0, a);
      @(posedge ref_clk);
      hw.tx_poll_done <= (k == 0);
      hw.rx_poll_done <= (k == 1);
      @(posedge ref_clk);
      hw.tx_poll_done <= 1'b0;
      hw.rx_poll_done <= 1'b0;
      rd(a, 32'h0);
    end
    $display("test poll demand done");
    @(posedge ref_clk);
    hw.tmr_upd <= 1'b1;
    hw.tmr_val <= $random(seed);
    v = $random(seed);
    wr(8'h58, v);
    check(ctrl.gen_timer, v, 8'h58);
    @(posedge ref_clk);
    hw.tmr_upd <= 1'b0;
    #1;
    check(ctrl.gen_timer, hw.tmr_val, 8'h58);
    @(posedge ref_clk);
    hw.drop_cnt <= $random(seed);
    hw.perf_cnt <= $random(seed);
    hw.tx_dptr <= $random(seed);
    hw.rx_dptr <= $random(seed);
    hw.serial_pins <= 16'hA5C3;
    foreach (ro_offs[i]) begin
      wr(ro_offs[i], ~ro_val(ro_offs[i]));
      rd(ro_offs[i], ro_val(ro_offs[i]));
    end
    v = $random(seed);
    wr(8'h48, v);
    rd(8'h48, {v[31:16], hw.serial_pins});
    $display("test read only words done");
    for (int b = 0; b < 32; b++) begin
      en = $random(seed);
      wr(8'h38, en);
      wr(8'h84, en);
      @(posedge ref_clk);
      hw.main_src <= IDLE_SRC ^ (32'h1 << b);
      hw.sec_src <= IDLE_SRC ^ (32'h1 << b);
      @(posedge ref_clk);
      hw.main_src <= IDLE_SRC;
      hw.sec_src <= IDLE_SRC;
      rd(8'h28, 32'h1 << b);
      check({31'h0, irq_main}, {31'h0, en[b]}, 8'h38);
      check({31'h0, irq_sec}, {31'h0, en[b]}, 8'h84);
      rd(8'h80, 32'h1 << b);
      rd(8'h80, 32'h0);
      wr(8'h28, ~(32'h1 << b));
      rd(8'h28, 32'h1 << b);
      wr(8'h28, 32'h1 << b);
      rd(8'h28, 32'h0);
    end
    wr(8'h38, 32'h0);
    wr(8'h84, 32'h0);
    $display("test status banks done");
    conclude();
  end
endmodule

// ### verif/lcm_host_model.sv
// Host bus model issuing register accesses
module lcm_host_model (
  input wire logic ref_clk,
  input wire logic [31:0] csr_rdata,
  input wire logic csr_rvalid,
  output lcm_pkg::lcm_req_s csr_req
);
  timeunit 1ns;
  timeprecision 1ps;
  import lcm_pkg::*;
  logic [31:0] last_rd;
  logic last_ok;
  initial begin
    csr_req = '0;
  end
  task automatic op(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    csr_req <= '{sel: 1'b1, wr: w, addr: a, wdata: d};
    @(posedge ref_clk);
    csr_req <= '{sel: 1'b0, wr: ~w, addr: ~a, wdata: ~d};
    #1;
    last_ok = (csr_rvalid === !w);
    last_rd = csr_rdata;
  endtask
endmodule

// ### verilog/lcm_csr_bank.sv
// Control and status register bank of the LAN controller
`include "lcm_params.svh"

module lcm_csr_bank (
  input wire logic ref_clk,
  input wire logic rst,
  input wire lcm_pkg::lcm_req_s csr_req,
  output logic [31:0] csr_rdata,
  output logic csr_rvalid,
  input wire lcm_pkg::lcm_hw_s hw,
  output lcm_pkg::lcm_ctrl_s ctrl,
  output logic tx_poll_stb,
  output logic rx_poll_stb,
  output logic irq_main,
  output logic irq_sec
);
  import lcm_pkg::*;

  logic [5:0] idx;
  logic wr_en, rd_en;
  logic [31:0] rd_word;
  logic [31:0] bus_access_q, rx_ring_q, tx_ring_q, net_access_q, gen_timer_q, wakeup_q, watchdog_q;
  logic [31:0] command_q, power_q, tx_burst_q, flash_q, sta_lo_q, sta_hi_q, grp_lo_q, grp_hi_q;
  logic [31:0] sgl_lo_q, sgl_hi_q, op_mode_q, ien_main_q, ien_sec_q, main_stat, sec_stat;
  logic [31:0] drop_cnt_q, perf_cnt_q, tx_dptr_q, rx_dptr_q, tx_poll_q, rx_poll_q, rdata_q;
  logic [15:0] serial_ctrl_q;
  logic lor_done_q, tx_poll_stb_q, rx_poll_stb_q, irq_main_q, irq_sec_q, rvalid_q;

  // Word index of a byte offset
  function automatic logic [5:0] word_of(input logic [7:0] off);
    word_of = off[`LCM_IDX_MSB:`LCM_IDX_LSB];
  endfunction

  // Write hit on one register
  function automatic logic wr_hit(input logic [7:0] off);
    wr_hit = wr_en && (idx == word_of(off));
  endfunction

  // Status bit kind from bit position and bank
  function automatic lcm_acc_e stat_kind(input logic mask_bank, input int bit_n);
    logic [1:0] grp;
    grp = 2'(bit_n / 8);
    stat_kind = lcm_acc_e'({mask_bank, grp});
  endfunction

  assign idx = word_of(csr_req.addr);
  assign wr_en = csr_req.sel && csr_req.wr;
  assign rd_en = csr_req.sel && !csr_req.wr;

  // Plain read/write registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bus_access_q <= `LCM_RST_BUS_ACCESS;
      net_access_q <= `LCM_RST_ZERO;
      wakeup_q <= `LCM_RST_ZERO;
      serial_ctrl_q <= 16'h0000;
    end else begin
      if (wr_hit(`LCM_OFF_BUS_ACCESS)) begin
        bus_access_q <= csr_req.wdata;
      end
      if (wr_hit(`LCM_OFF_NET_ACCESS)) begin
        net_access_q <= csr_req.wdata;
      end
      if (wr_hit(`LCM_OFF_WAKEUP)) begin
        wakeup_q <= csr_req.wdata;
      end
      if (wr_hit(`LCM_OFF_SERIAL)) begin
        serial_ctrl_q <= csr_req.wdata[31:`LCM_SER_CTRL_LSB];
      end
    end
  end

  // Descriptor ring bases
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rx_ring_q <= `LCM_RST_ZERO;
      tx_ring_q <= `LCM_RST_ZERO;
    end else begin
      if (wr_hit(`LCM_OFF_RX_RING)) begin
        rx_ring_q <= csr_req.wdata;
      end
      if (wr_hit(`LCM_OFF_TX_RING)) begin
        tx_ring_q <= csr_req.wdata;
      end
    end
  end

  // Watchdog, power, transmit burst and flash port
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      watchdog_q <= `LCM_RST_ZERO;
      power_q <= `LCM_RST_ZERO;
      tx_burst_q <= `LCM_RST_ZERO;
      flash_q <= `LCM_RST_ZERO;
    end else begin
      if (wr_hit(`LCM_OFF_WATCHDOG)) begin
        watchdog_q <= csr_req.wdata;
      end
      if (wr_hit(`LCM_OFF_POWER)) begin
        power_q <= csr_req.wdata;
      end
      if (wr_hit(`LCM_OFF_TX_BURST)) begin
        tx_burst_q <= csr_req.wdata;
      end
      if (wr_hit(`LCM_OFF_FLASH)) begin
        flash_q <= csr_req.wdata;
      end
    end
  end

  // General timer, hardware reloadable
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      gen_timer_q <= `LCM_RST_ZERO;
    end else if (wr_hit(`LCM_OFF_GEN_TIMER)) begin
      gen_timer_q <= csr_req.wdata;
    end else if (hw.tmr_upd) begin
      gen_timer_q <= hw.tmr_val;
    end
  end

  // Command register loads straps once
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      command_q <= `LCM_RST_ZERO;
      lor_done_q <= 1'b0;
    end else begin
      lor_done_q <= 1'b1;
      if (wr_hit(`LCM_OFF_COMMAND)) begin
        command_q <= csr_req.wdata;
      end else if (!lor_done_q) begin
        command_q <= hw.strap;
      end
    end
  end

  // Address filters and operating mode
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sta_lo_q <= `LCM_RST_ZERO;
      sta_hi_q <= `LCM_RST_ZERO;
      grp_lo_q <= `LCM_RST_ZERO;
      grp_hi_q <= `LCM_RST_ZERO;
      sgl_lo_q <= `LCM_RST_ZERO;
      sgl_hi_q <= `LCM_RST_ZERO;
      op_mode_q <= `LCM_RST_ZERO;
    end else begin
      if (wr_hit(`LCM_OFF_STA_LO)) begin
        sta_lo_q <= csr_req.wdata;
      end
      if (wr_hit(`LCM_OFF_STA_HI)) begin
        sta_hi_q <= csr_req.wdata;
      end
      if (wr_hit(`LCM_OFF_GRP_LO)) begin
        grp_lo_q <= csr_req.wdata;
      end
      if (wr_hit(`LCM_OFF_GRP_HI)) begin
        grp_hi_q <= csr_req.wdata;
      end
      if (wr_hit(`LCM_OFF_SGL_LO)) begin
        sgl_lo_q <= csr_req.wdata;
      end
      if (wr_hit(`LCM_OFF_SGL_HI)) begin
        sgl_hi_q <= csr_req.wdata;
      end
      if (wr_hit(`LCM_OFF_OP_MODE)) begin
        op_mode_q <= csr_req.wdata;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      drop_cnt_q <= `LCM_RST_ZERO;
      perf_cnt_q <= `LCM_RST_ZERO;
      tx_dptr_q <= `LCM_RST_ZERO;
      rx_dptr_q <= `LCM_RST_ZERO;
    end else begin
      drop_cnt_q <= hw.drop_cnt;
      perf_cnt_q <= hw.perf_cnt;
      tx_dptr_q <= hw.tx_dptr;
      rx_dptr_q <= hw.rx_dptr;
    end
  end

  // Poll demand registers and strobes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_poll_q <= `LCM_RST_ZERO;
      rx_poll_q <= `LCM_RST_ZERO;
      tx_poll_stb_q <= 1'b0;
      rx_poll_stb_q <= 1'b0;
    end else begin
      tx_poll_stb_q <= wr_hit(`LCM_OFF_TX_POLL);
      rx_poll_stb_q <= wr_hit(`LCM_OFF_RX_POLL);
      if (wr_hit(`LCM_OFF_TX_POLL)) begin
        tx_poll_q <= csr_req.wdata;
      end else if (hw.tx_poll_done) begin
        tx_poll_q <= `LCM_RST_ZERO;
      end
      if (wr_hit(`LCM_OFF_RX_POLL)) begin
        rx_poll_q <= csr_req.wdata;
      end else if (hw.rx_poll_done) begin
        rx_poll_q <= `LCM_RST_ZERO;
      end
    end
  end

  // Interrupt enables
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ien_main_q <= `LCM_RST_ZERO;
      ien_sec_q <= `LCM_RST_ZERO;
    end else begin
      if (wr_hit(`LCM_OFF_IEN_MAIN)) begin
        ien_main_q <= csr_req.wdata;
      end
      if (wr_hit(`LCM_OFF_IEN_SEC)) begin
        ien_sec_q <= csr_req.wdata;
      end
    end
  end

  // Status bits: main bank mask-clear, secondary bank read-clear
  for (genvar i = 0; i < 32; i++) begin : g_stat
    // main bank cleared by written ones
    lcm_stat_cell #(
      .KIND(stat_kind(1'b1, i))
    ) u_main (
      .ref_clk(ref_clk),
      .rst(rst),
      .src(hw.main_src[i]),
      .rd_clr(rd_en && (idx == word_of(`LCM_OFF_MAIN_STAT))),
      .wr_clr(wr_en && (idx == word_of(`LCM_OFF_MAIN_STAT)) && csr_req.wdata[i]),
      .flag_q(main_stat[i])
    );
    lcm_stat_cell #(
      .KIND(stat_kind(1'b0, i))
    ) u_sec (
      .ref_clk(ref_clk),
      .rst(rst),
      .src(hw.sec_src[i]),
      .rd_clr(rd_en && (idx == word_of(`LCM_OFF_SEC_STAT))),
      .wr_clr(wr_en && (idx == word_of(`LCM_OFF_SEC_STAT)) && csr_req.wdata[i]),
      .flag_q(sec_stat[i])
    );
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_main_q <= 1'b0;
      irq_sec_q <= 1'b0;
    end else begin
      irq_main_q <= |(main_stat & ien_main_q);
      irq_sec_q <= |(sec_stat & ien_sec_q);
    end
  end

  // Read multiplexer
  always_comb begin
    case (idx)
      word_of(`LCM_OFF_BUS_ACCESS): rd_word = bus_access_q;
      word_of(`LCM_OFF_TX_POLL): rd_word = tx_poll_q;
      word_of(`LCM_OFF_RX_POLL): rd_word = rx_poll_q;
      word_of(`LCM_OFF_RX_RING): rd_word = rx_ring_q;
      word_of(`LCM_OFF_TX_RING): rd_word = tx_ring_q;
      word_of(`LCM_OFF_MAIN_STAT): rd_word = main_stat;
      word_of(`LCM_OFF_NET_ACCESS): rd_word = net_access_q;
      word_of(`LCM_OFF_IEN_MAIN): rd_word = ien_main_q;
      word_of(`LCM_OFF_DROP_CNT): rd_word = drop_cnt_q;
      word_of(`LCM_OFF_SERIAL): rd_word = {serial_ctrl_q, hw.serial_pins};
      word_of(`LCM_OFF_GEN_TIMER): rd_word = gen_timer_q;
      word_of(`LCM_OFF_WAKEUP): rd_word = wakeup_q;
      word_of(`LCM_OFF_WATCHDOG): rd_word = watchdog_q;
      word_of(`LCM_OFF_SEC_STAT): rd_word = sec_stat;
      word_of(`LCM_OFF_IEN_SEC): rd_word = ien_sec_q;
      word_of(`LCM_OFF_COMMAND): rd_word = command_q;
      word_of(`LCM_OFF_PERF_CNT): rd_word = perf_cnt_q;
      word_of(`LCM_OFF_POWER): rd_word = power_q;
      word_of(`LCM_OFF_TX_DPTR): rd_word = tx_dptr_q;
      word_of(`LCM_OFF_RX_DPTR): rd_word = rx_dptr_q;
      word_of(`LCM_OFF_TX_BURST): rd_word = tx_burst_q;
      word_of(`LCM_OFF_FLASH): rd_word = flash_q;
      word_of(`LCM_OFF_STA_LO): rd_word = sta_lo_q;
      word_of(`LCM_OFF_STA_HI): rd_word = sta_hi_q;
      word_of(`LCM_OFF_GRP_LO): rd_word = grp_lo_q;
      word_of(`LCM_OFF_GRP_HI): rd_word = grp_hi_q;
      word_of(`LCM_OFF_SGL_LO): rd_word = sgl_lo_q;
      word_of(`LCM_OFF_SGL_HI): rd_word = sgl_hi_q;
      word_of(`LCM_OFF_OP_MODE): rd_word = op_mode_q;
      default: rd_word = `LCM_RST_ZERO;
    endcase
  end

  // Read data register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_q <= `LCM_RST_ZERO;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= rd_en;
      if (rd_en) begin
        rdata_q <= rd_word;
      end
    end
  end

  // Control outputs from flops
  assign ctrl = {bus_access_q, rx_ring_q, tx_ring_q, net_access_q, serial_ctrl_q, gen_timer_q, wakeup_q,
    watchdog_q, command_q, power_q, tx_burst_q, flash_q, sta_lo_q, sta_hi_q, grp_lo_q, grp_hi_q, sgl_lo_q,
    sgl_hi_q, op_mode_q};

  assign csr_rdata = rdata_q;
  assign csr_rvalid = rvalid_q;
  assign tx_poll_stb = tx_poll_stb_q;
  assign rx_poll_stb = rx_poll_stb_q;
  assign irq_main = irq_main_q;
  assign irq_sec = irq_sec_q;
endmodule

// ### verilog/lcm_stat_cell.sv
// One sticky status bit of a selectable latch or edge kind
module lcm_stat_cell #(
  parameter lcm_pkg::lcm_acc_e KIND = lcm_pkg::LCM_ACC_LHMK
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic src,
  input wire logic rd_clr,
  input wire logic wr_clr,
  output logic flag_q
);
  import lcm_pkg::*;

  logic src_q;
  logic set;
  logic clr;

  // Previous source level for edge kinds
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      src_q <= 1'b0;
    end else begin
      src_q <= src;
    end
  end

  always_comb begin
    case (KIND)
      LCM_ACC_LHSC, LCM_ACC_LHMK: set = src;
      LCM_ACC_LLSC, LCM_ACC_LLMK: set = !src;
      LCM_ACC_IHSC, LCM_ACC_IHMK: set = src & !src_q;
      default: set = !src & src_q;
    endcase
  end

  assign clr = KIND[2] ? wr_clr : rd_clr;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flag_q <= 1'b0;
    end else if (set) begin
      flag_q <= 1'b1;
    end else if (clr) begin
      flag_q <= 1'b0;
    end
  end
endmodule
